// *** shared/fmsc_pkg.sv ***
// Purpose: constants for the fault monitor status and control register
// Assumes: one 16-bit register on a simple parallel register port
// Notes:   bit positions, masks, reset value and timing counts live here

package fmsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] FMSC_ADDR_FAULT = 8'h0e; // fault_alarm_status_control
    localparam logic [15:0] FMSC_RST_VAL = 16'h0000; // everything clear at reset
    localparam logic [15:0] FMSC_RW_MASK = 16'hff2c; // masks plus unused storage bits

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FMSC_B_PUV_MASK = 15; // pump_undervolt_alarm_mask
    localparam int FMSC_B_HB_MASK = 14; // heartbeat_alarm_mask
    localparam int FMSC_B_REF_MASK = 12; // refpin_open_alarm_mask
    localparam int FMSC_B_VDD_MASK = 9; // logic_supply_open_alarm_mask
    localparam int FMSC_B_GND_MASK = 8; // logic_ground_open_alarm_mask
    localparam int FMSC_B_PUV_ALRT = 7; // pump_undervolt_alert
    localparam int FMSC_B_HB_ALRT = 6; // heartbeat_freq_alert
    localparam int FMSC_B_REF_ALRT = 4; // refpin_oscillation_alert
    localparam int FMSC_B_VDD_ALRT = 1; // logic_supply_open_alert
    localparam int FMSC_B_GND_ALRT = 0; // logic_ground_open_alert

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FMSC_CLK_NS = 100; // system clock period
    localparam int FMSC_HB_NOM_NS = 61035; // two periods of the 32.768 kHz clock
    // tolerance 12.5 %: frequency band 7/8..9/8 of nominal, so period 8/9..8/7
    localparam int FMSC_HB_MIN_CYC = (FMSC_HB_NOM_NS * 8 + 9 * FMSC_CLK_NS - 1)
                                     / (9 * FMSC_CLK_NS);
    localparam int FMSC_HB_MAX_CYC = (FMSC_HB_NOM_NS * 8) / (7 * FMSC_CLK_NS);
    localparam int FMSC_REF_WIN_LS = 4; // low-speed periods per counting window
    localparam int FMSC_REF_HITS = 4; // rising ref transitions that flag

endpackage : fmsc_pkg

// *** src/fmsc_fault_reg.sv ***
// Purpose: fault status and control register with alarm masking
// Assumes: all inputs synchronous to i_sys_clk; 10 MHz clock
// Notes:   alerts are sticky, cleared by writing 0; set beats clear

`timescale 1ns/1ps

module fmsc_fault_reg #(
    parameter int HB_CNT_W = 10 // heartbeat period counter width
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata_r,
    output logic o_reg_rvalid_r,
    // fault detector inputs
    input wire logic i_pump_undervolt,
    input wire logic i_logic_supply_open,
    input wire logic i_logic_ground_open,
    input wire logic i_reset_status_flag,
    input wire logic i_heartbeat,
    // converter and reference pin
    input wire logic i_scan_start,
    input wire logic i_adc_busy,
    input wire logic i_adc_strobe,
    input wire logic i_lsclk,
    input wire logic i_ref_pin,
    // alarm
    output logic o_alarm_r
);
    import fmsc_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if ((2 ** HB_CNT_W) <= FMSC_HB_MAX_CYC + 1) begin : g_bad_w
        $error("HB_CNT_W too small for heartbeat period");
    end

    localparam logic [HB_CNT_W-1:0] HB_MIN = HB_CNT_W'(FMSC_HB_MIN_CYC);
    localparam logic [HB_CNT_W-1:0] HB_MAX = HB_CNT_W'(FMSC_HB_MAX_CYC);
    localparam logic [2:0] WIN_LEN = 3'(FMSC_REF_WIN_LS);
    localparam logic [2:0] REF_HITS = 3'(FMSC_REF_HITS);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] ctl_r; // mask and unused storage bits
    logic [4:0] alert_r; // {puv, hb, ref, vdd, gnd}
    logic [4:0] alert_nxt; // next alert value
    logic [4:0] set_vec; // detector set requests
    logic [4:0] clr_vec; // software clear requests
    logic [4:0] mask_vec; // masks in alert order
    logic [15:0] rd_word; // assembled read value
    logic sel; // register selected
    logic wr_hit; // write to this register
    logic hb_prev_r; // heartbeat last sample
    logic hb_seen_r; // first heartbeat edge seen
    logic [HB_CNT_W-1:0] hb_cnt_r; // cycles since last heartbeat edge
    logic hb_err; // heartbeat period out of band
    logic ref_armed_r; // valid scan started
    logic busy_prev_r; // converter busy last cycle
    logic win_r; // counting window open
    logic [2:0] win_cnt_r; // low-speed edges in window
    logic [2:0] ref_cnt_r; // ref rising edges in window
    logic ls_prev_r; // low-speed clock last sample
    logic ref_prev_r; // ref pin last sample
    logic ls_rise; // low-speed rising edge
    logic ref_rise; // ref pin rising edge
    logic ref_hit; // fourth ref edge in window

    // ------------------------------------------------------------
    // decode and read assembly
    // ------------------------------------------------------------
    assign sel = (i_reg_addr == FMSC_ADDR_FAULT);
    assign wr_hit = sel && i_reg_wr;
    assign mask_vec = {ctl_r[FMSC_B_PUV_MASK], ctl_r[FMSC_B_HB_MASK],
                       ctl_r[FMSC_B_REF_MASK], ctl_r[FMSC_B_VDD_MASK],
                       ctl_r[FMSC_B_GND_MASK]};

    always_comb begin
        rd_word = ctl_r & FMSC_RW_MASK;
        rd_word[FMSC_B_PUV_ALRT] = alert_r[4];
        rd_word[FMSC_B_HB_ALRT] = alert_r[3];
        rd_word[FMSC_B_REF_ALRT] = alert_r[2];
        rd_word[FMSC_B_VDD_ALRT] = alert_r[1];
        rd_word[FMSC_B_GND_ALRT] = alert_r[0];
    end

    // ------------------------------------------------------------
    // software storage bits
    // ------------------------------------------------------------
    // masks and unused bits take the written value directly
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ctl_r <= FMSC_RST_VAL;
        end else if (wr_hit) begin
            ctl_r <= i_reg_wdata & FMSC_RW_MASK;
        end
    end

    // read data registered, unmapped address reads zero
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata_r <= 16'h0000;
            o_reg_rvalid_r <= 1'b0;
        end else begin
            o_reg_rvalid_r <= i_reg_rd;
            o_reg_rdata_r <= (i_reg_rd && sel) ? rd_word : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // heartbeat period check
    // ------------------------------------------------------------
    // measured between rising edges; a stalled heartbeat overruns max
    assign hb_err = hb_seen_r && (((i_heartbeat && !hb_prev_r) && (hb_cnt_r < HB_MIN))
                    || (hb_cnt_r > HB_MAX));

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            hb_prev_r <= 1'b0;
            hb_seen_r <= 1'b0;
            hb_cnt_r <= '0;
        end else begin
            hb_prev_r <= i_heartbeat;
            if (i_heartbeat && !hb_prev_r) begin
                hb_seen_r <= 1'b1;
                hb_cnt_r <= HB_CNT_W'(1);
            end else if (hb_cnt_r <= HB_MAX) begin
                hb_cnt_r <= hb_cnt_r + HB_CNT_W'(1); // saturate just past max
            end
        end
    end

    // ------------------------------------------------------------
    // reference pin oscillation check
    // ------------------------------------------------------------
    assign ls_rise = i_lsclk && !ls_prev_r;
    assign ref_rise = i_ref_pin && !ref_prev_r;
    // the edge that reaches the count flags at once
    assign ref_hit = win_r && ref_rise && (ref_cnt_r == REF_HITS - 3'd1);

    // armed only by a start that the converter accepts
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ref_armed_r <= 1'b0;
            busy_prev_r <= 1'b0;
        end else begin
            busy_prev_r <= i_adc_busy;
            if (i_scan_start && !i_adc_busy) begin
                ref_armed_r <= 1'b1;
            end else if (busy_prev_r && !i_adc_busy) begin
                ref_armed_r <= 1'b0; // scan finished
            end
        end
    end

    // window opened by each strobe while armed, closed after four low-speed periods
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            win_r <= 1'b0;
            win_cnt_r <= 3'd0;
            ref_cnt_r <= 3'd0;
            ls_prev_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            ls_prev_r <= i_lsclk;
            ref_prev_r <= i_ref_pin;
            if (i_adc_strobe && ref_armed_r) begin
                win_r <= 1'b1;
                win_cnt_r <= 3'd0;
                ref_cnt_r <= 3'd0;
            end else if (win_r) begin
                if (ls_rise) begin
                    win_cnt_r <= win_cnt_r + 3'd1;
                    if (win_cnt_r == WIN_LEN - 3'd1) begin
                        win_r <= 1'b0;
                    end
                end
                if (ref_rise && ref_cnt_r != REF_HITS) begin
                    ref_cnt_r <= ref_cnt_r + 3'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sticky alerts
    // ------------------------------------------------------------
    // the reference alert is not held off by the reset-status flag
    assign set_vec = {i_pump_undervolt && !i_reset_status_flag,
                      hb_err && !i_reset_status_flag,
                      ref_hit,
                      i_logic_supply_open && !i_reset_status_flag,
                      i_logic_ground_open && !i_reset_status_flag};
    assign clr_vec = {5{wr_hit}} & ~{i_reg_wdata[FMSC_B_PUV_ALRT],
                     i_reg_wdata[FMSC_B_HB_ALRT], i_reg_wdata[FMSC_B_REF_ALRT],
                     i_reg_wdata[FMSC_B_VDD_ALRT], i_reg_wdata[FMSC_B_GND_ALRT]};

    for (genvar gi = 0; gi < 5; gi++) begin : g_alert
        // a detector set in the clearing cycle wins over the clear
        assign alert_nxt[gi] = set_vec[gi] || (alert_r[gi] && !clr_vec[gi]);

        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
                alert_r[gi] <= 1'b0;
            end else begin
                alert_r[gi] <= alert_nxt[gi];
            end
        end
    end

    // ------------------------------------------------------------
    // alarm output
    // ------------------------------------------------------------
    // registered for a clean pin; lags the alert bits by one cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_alarm_r <= 1'b0;
        end else begin
            o_alarm_r <= |(alert_r & mask_vec);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_alarm_masked_or: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 o_alarm_r == |($past(alert_r) & $past(mask_vec)))
        else $error("alarm differs from masked alerts");

    a_puv_mask_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (alert_r[4] && ctl_r[FMSC_B_PUV_MASK]) |=> o_alarm_r)
        else $error("pump undervolt alert did not raise alarm");

    a_hb_mask_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (alert_r[3] && ctl_r[FMSC_B_HB_MASK]) |=> o_alarm_r)
        else $error("heartbeat alert did not raise alarm");

    a_alarm_quiet_masks: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((alert_r & mask_vec) == 5'd0) |=> !o_alarm_r)
        else $error("alarm raised with every alert masked");

    a_hold_reset_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reset_status_flag && !alert_r[0] && !alert_r[1]) |=> (!alert_r[0] && !alert_r[1]))
        else $error("logic pin alert set while reset status high");

    a_one_write_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_hit && alert_r[4] && i_reg_wdata[FMSC_B_PUV_ALRT]) |=> alert_r[4])
        else $error("writing 1 changed pump alert");

    a_zero_write_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_hit && !i_reg_wdata[FMSC_B_GND_ALRT] && !set_vec[0]) |=> !alert_r[0])
        else $error("writing 0 did not clear ground alert");

    a_alert_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (alert_r[1] && !(wr_hit && !i_reg_wdata[FMSC_B_VDD_ALRT])) |=> alert_r[1])
        else $error("supply alert dropped without a clear");

    a_unused_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        wr_hit ##1 (i_reg_rd && sel && !wr_hit) |=>
        ((o_reg_rdata_r & 16'h2c2c) == ($past(i_reg_wdata, 2) & 16'h2c2c)))
        else $error("unused bits did not read back");

    a_ref_needs_window: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (!alert_r[2] && !win_r) |=> !alert_r[2])
        else $error("ref alert set with no counting window");

    a_busy_start_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (!ref_armed_r && i_scan_start && i_adc_busy) |=> !ref_armed_r)
        else $error("busy scan start armed the ref check");

    a_window_bounded: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (win_r && ls_rise && win_cnt_r == WIN_LEN - 3'd1 && !i_adc_strobe) |=> !win_r)
        else $error("window outlived four low-speed periods");

    a_hb_stall_flags: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (hb_seen_r && hb_cnt_r > HB_MAX && !i_reset_status_flag) |=> alert_r[3])
        else $error("stalled heartbeat not flagged");

endmodule : fmsc_fault_reg

// *** dv/tb.sv ***
// Purpose: self-checking bench for the fault monitor status and control register
// Assumes: 10 MHz system clock, synchronous active-low reset, parallel register port
// Notes:   inputs change 1 ns after each rising edge; expectations kept in exp_r

`timescale 1ns/1ps

module tb;
    import fmsc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0; // system clock
    logic i_rst_n = 1'b0; // held low at start
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [15:0] o_reg_rdata_r;
    logic o_reg_rvalid_r;
    logic i_pump_undervolt = 1'b0;
    logic i_logic_supply_open = 1'b0;
    logic i_logic_ground_open = 1'b0;
    logic i_reset_status_flag = 1'b1; // pump, heartbeat and logic pin alerts blocked until cleared
    logic i_heartbeat = 1'b0;
    logic i_scan_start = 1'b0;
    logic i_adc_busy = 1'b0;
    logic i_adc_strobe = 1'b0;
    logic i_lsclk = 1'b0;
    logic i_ref_pin = 1'b0;
    logic o_alarm_r;
    logic [15:0] exp_r = 16'h0000; // expected register contents
    logic hb_run = 1'b1; // heartbeat generator enable
    int hb_half = 300; // heartbeat half period in cycles
    int hb_cnt = 0;
    int ls_cnt = 0;
    int miscompares = 0;
    int n_tests = 0;
    localparam logic [15:0] ALERTS = 16'h00d3; // alert bit positions
    localparam int MB[5] = '{FMSC_B_PUV_MASK, FMSC_B_HB_MASK, FMSC_B_REF_MASK,
                             FMSC_B_VDD_MASK, FMSC_B_GND_MASK};
    localparam int AB[5] = '{FMSC_B_PUV_ALRT, FMSC_B_HB_ALRT, FMSC_B_REF_ALRT,
                             FMSC_B_VDD_ALRT, FMSC_B_GND_ALRT};

    // ------------------------------------------------------------
    // design under test
    // ------------------------------------------------------------
    fmsc_fault_reg #(.HB_CNT_W(10)) u_fmsc_fault_reg (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata_r(o_reg_rdata_r), .o_reg_rvalid_r(o_reg_rvalid_r),
        .i_pump_undervolt(i_pump_undervolt), .i_logic_supply_open(i_logic_supply_open),
        .i_logic_ground_open(i_logic_ground_open),
        .i_reset_status_flag(i_reset_status_flag), .i_heartbeat(i_heartbeat),
        .i_scan_start(i_scan_start), .i_adc_busy(i_adc_busy), .i_adc_strobe(i_adc_strobe),
        .i_lsclk(i_lsclk), .i_ref_pin(i_ref_pin), .o_alarm_r(o_alarm_r));

    // ------------------------------------------------------------
    // clocks and slow signal generators
    // ------------------------------------------------------------
    // system clock, 100 ns period
    always #50 i_sys_clk = ~i_sys_clk;

    // heartbeat period 600 cycles sits inside the tolerance band; low-speed clock ~304
    always @(posedge i_sys_clk) begin
        #1;
        hb_cnt++;
        ls_cnt++;
        if (hb_run && hb_cnt >= hb_half) begin // stopping it models a dead heartbeat
            hb_cnt = 0;
            i_heartbeat = ~i_heartbeat;
        end
        if (ls_cnt >= 152) begin
            ls_cnt = 0;
            i_lsclk = ~i_lsclk;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // every task starts and ends 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc

    task automatic chk16(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic want);
        n_tests++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk1

    // one-cycle write strobe; model keeps storage and clears alerts written 0
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        i_reg_addr = addr;
        i_reg_wdata = data;
        i_reg_wr = 1'b1;
        cyc(1);
        i_reg_wr = 1'b0;
        if (addr == FMSC_ADDR_FAULT) begin
            exp_r = (data & FMSC_RW_MASK) | (exp_r & data & ALERTS);
        end
    endtask : wr

    // read data stands one cycle after the strobe edge
    task automatic rd_chk(input logic [7:0] addr, input logic [15:0] want);
        i_reg_addr = addr;
        i_reg_rd = 1'b1;
        cyc(1);
        i_reg_rd = 1'b0;
        chk1(o_reg_rvalid_r, 1'b1);
        chk16(o_reg_rdata_r, want);
    endtask : rd_chk

    // each mask alone: alarm follows only its own alert
    task automatic masks_chk();
        for (int i = 0; i < 5; i++) begin
            wr(FMSC_ADDR_FAULT, (16'h0001 << MB[i]) | ALERTS);
            cyc(2);
            chk1(o_alarm_r, exp_r[AB[i]]);
        end
        wr(FMSC_ADDR_FAULT, ALERTS);
        cyc(2);
        chk1(o_alarm_r, 1'b0);
    endtask : masks_chk

    task automatic ref_edges(input int n);
        repeat (n) begin
            i_ref_pin = 1'b1;
            cyc(2);
            i_ref_pin = 1'b0;
            cyc(2);
        end
    endtask : ref_edges

    task automatic pulse_strobe();
        i_adc_strobe = 1'b1;
        cyc(1);
        i_adc_strobe = 1'b0;
    endtask : pulse_strobe

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    // whole sequence needs about 4800 cycles
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        cyc(12);
        i_rst_n = 1'b1;
        rd_chk(FMSC_ADDR_FAULT, FMSC_RST_VAL);
        wr(8'h0d, 16'hffff);
        rd_chk(8'h0d, 16'h0000);
        cyc(1); // read strobe drops for a cycle between two reads
        rd_chk(FMSC_ADDR_FAULT, 16'h0000);
        wr(FMSC_ADDR_FAULT, 16'hffff);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        wr(FMSC_ADDR_FAULT, 16'h0000);
        rd_chk(FMSC_ADDR_FAULT, 16'h0000);
        $display("test register access done");
        // detectors active while the reset-status flag is still high
        {i_pump_undervolt, i_logic_supply_open, i_logic_ground_open} = 3'b111;
        cyc(3);
        rd_chk(FMSC_ADDR_FAULT, 16'h0000);
        {i_pump_undervolt, i_logic_supply_open, i_logic_ground_open} = 3'b000;
        i_reset_status_flag = 1'b0;
        cyc(3);
        rd_chk(FMSC_ADDR_FAULT, 16'h0000);
        i_logic_ground_open = 1'b1;
        cyc(2);
        i_logic_ground_open = 1'b0;
        exp_r[FMSC_B_GND_ALRT] = 1'b1;
        cyc(2);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        masks_chk();
        {i_pump_undervolt, i_logic_supply_open} = 2'b11;
        cyc(2);
        {i_pump_undervolt, i_logic_supply_open} = 2'b00;
        exp_r[FMSC_B_PUV_ALRT] = 1'b1;
        exp_r[FMSC_B_VDD_ALRT] = 1'b1;
        cyc(3);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        masks_chk();
        wr(FMSC_ADDR_FAULT, 16'hff7f);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        wr(FMSC_ADDR_FAULT, 16'h0000);
        rd_chk(FMSC_ADDR_FAULT, 16'h0000);
        $display("test alerts and masks done");
        // in-band heartbeat for several periods, then a fast one, then a stopped one
        cyc(1500);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        // heartbeat period of 400 cycles falls below the band
        hb_half = 200;
        cyc(1000);
        exp_r[FMSC_B_HB_ALRT] = 1'b1;
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        hb_run = 1'b0;
        cyc(1); // a last toggle reaches the design before the clear
        wr(FMSC_ADDR_FAULT, 16'h0000);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        cyc(800);
        exp_r[FMSC_B_HB_ALRT] = 1'b1;
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        $display("test heartbeat done");
        // scan request while busy is ignored, so a strobe opens no window
        i_adc_busy = 1'b1;
        i_scan_start = 1'b1;
        cyc(1);
        i_scan_start = 1'b0;
        pulse_strobe();
        ref_edges(4);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        i_adc_busy = 1'b0;
        cyc(1);
        i_scan_start = 1'b1;
        cyc(1);
        i_scan_start = 1'b0;
        i_adc_busy = 1'b1;
        ref_edges(4);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        pulse_strobe();
        ref_edges(3);
        cyc(1300);
        ref_edges(1);
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        pulse_strobe();
        ref_edges(4);
        exp_r[FMSC_B_REF_ALRT] = 1'b1;
        rd_chk(FMSC_ADDR_FAULT, exp_r);
        $display("test reference check done");
        masks_chk();
        $display("test final masks done");
        finish_test();
    end

endmodule : tb
